// ### shared/ocss_pkg.sv
// Package for the output clock source select block: offsets, fields, resets, codes
package ocss_pkg;

	// ************************************************
	// Register offsets
	// ************************************************
	localparam logic [15:0] OCSS_ADDR_SYNC_LOW = 16'h00A8;
	localparam logic [15:0] OCSS_ADDR_OUT45 = 16'h00A9;
	localparam logic [15:0] OCSS_ADDR_OUT67 = 16'h00AA;
	localparam logic [15:0] OCSS_ADDR_RSVD = 16'h00AB;

	// ************************************************
	// Field positions
	// ************************************************
	localparam int OCSS_POS_SYNC0 = 4;
	localparam int OCSS_POS_SYNC1 = 5;
	localparam int OCSS_POS_LO_PICK = 4;
	localparam int OCSS_POS_HI_PICK = 0;

	// ************************************************
	// Reset values
	// ************************************************
	localparam logic [3:0] OCSS_RST_LOW_PICK = 4'ha;
	localparam logic [2:0] OCSS_RST_PICK4 = 3'h0;
	localparam logic [2:0] OCSS_RST_PICK5 = 3'h2;
	localparam logic [2:0] OCSS_RST_PICK6 = 3'h6;
	localparam logic [2:0] OCSS_RST_PICK7 = 3'h5;
	localparam logic [7:0] OCSS_RSVD_READ = 8'h00;

	// ************************************************
	// Source codes of the three-bit selects
	// ************************************************
	typedef enum logic [2:0] {
		OCSS_SRC_FIRST_PLL = 3'b000,
		OCSS_SRC_SECOND_PLL = 3'b001,
		OCSS_SRC_OUT2 = 3'b010,
		OCSS_SRC_OUT3 = 3'b011,
		OCSS_SRC_REF0 = 3'b100,
		OCSS_SRC_REF1 = 3'b101,
		OCSS_SRC_REF2 = 3'b110,
		OCSS_SRC_XTAL = 3'b111
	} ocss_src_t;

	// Count of source inputs to the wide mux
	localparam int OCSS_NUM_SRC = 8;
	localparam int OCSS_NUM_OUT = 8;

endpackage

// ### logic/ocss_sync_ctl.sv
// One PLL's divider sync sequencer: hold on rise, release on fall
`timescale 1ns/1ps
module ocss_sync_ctl
	import ocss_pkg::*;
(
	input wire logic i_clk, // System clock
	input wire logic i_arst_n, // Async reset, active low
	input wire logic i_sync_bit, // Software sync bit for this PLL
	output logic o_hold, // Hold dividers of this PLL
	output logic o_release // One-cycle release pulse
);

	typedef enum logic [0:0] {
		OCSS_ST_RUN = 1'b0,
		OCSS_ST_HOLD = 1'b1
	} ocss_sync_st_t;

	ocss_sync_st_t state;
	ocss_sync_st_t next_state;
	logic bit_q;

	// Previous bit value, for edge detection
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bit_q <= 1'b0;
		end else begin
			bit_q <= i_sync_bit;
		end
	end

	// Next state from bit edges
	always_comb begin
		next_state = state;
		case (state)
			OCSS_ST_RUN: begin
				if (i_sync_bit && !bit_q) begin
					next_state = OCSS_ST_HOLD;
				end
			end
			OCSS_ST_HOLD: begin
				if (!i_sync_bit && bit_q) begin
					next_state = OCSS_ST_RUN;
				end
			end
			default: begin
				next_state = OCSS_ST_RUN;
			end
		endcase
	end

	// State and registered outputs
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= OCSS_ST_RUN;
			o_hold <= 1'b0;
			o_release <= 1'b0;
		end else begin
			state <= next_state;
			o_hold <= (next_state == OCSS_ST_HOLD);
			o_release <= (state == OCSS_ST_HOLD) && (next_state == OCSS_ST_RUN);
		end
	end

endmodule

// ### logic/ocss_top.sv
// Output clock source select and divider sync control, register-driven
`timescale 1ns/1ps
module ocss_top
	import ocss_pkg::*;
#(
	parameter int NUM_OUT = OCSS_NUM_OUT // Output count
)(
	input wire logic i_clk, // System clock, 40 MHz
	input wire logic i_arst_n, // Async reset, active low
	input wire logic [15:0] i_reg_addr, // Register address
	input wire logic [7:0] i_reg_wdata, // Write data
	input wire logic i_reg_wr, // Write strobe
	input wire logic i_reg_rd, // Read strobe
	output logic [7:0] o_reg_rdata, // Read data
	output logic [7:0] o_reg_out_pick_code, // Registered: outputs 0-3 bits, sync bits
	output logic [3:0] o_low_pick, // Outputs 0-3 PLL select, 1 = second PLL
	output logic [2:0] o_out4_source_pick, // Output 4 source code
	output logic [2:0] o_out5_source_pick, // Output 5 source code
	output logic [2:0] o_out6_source_pick, // Output 6 source code
	output logic [2:0] o_out7_source_pick, // Output 7 source code
	output logic [NUM_OUT-1:0] o_from_first_pll, // Output driven by first PLL
	output logic [NUM_OUT-1:0] o_from_second_pll, // Output driven by second PLL
	output logic [NUM_OUT-1:0] o_div_hold, // Divider held in reset
	output logic [NUM_OUT-1:0] o_coarse_clear, // Pulse: clear coarse phase
	output logic [NUM_OUT-1:0] o_fine_apply // Pulse: load fine phase
);

	// ************************************************
	// Register storage
	// ************************************************
	logic [3:0] out_pick; // Bit m selects source for output m
	logic first_pll_divider_sync;
	logic second_pll_divider_sync;
	logic [2:0] out4_source_pick;
	logic [2:0] out5_source_pick;
	logic [2:0] out6_source_pick;
	logic [2:0] out7_source_pick;

	logic [NUM_OUT-1:0] next_first;
	logic [NUM_OUT-1:0] next_second;
	logic hold0;
	logic hold1;
	logic rel0;
	logic rel1;

	// Writes; reserved bits are dropped, so they read back as zero
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			out_pick <= OCSS_RST_LOW_PICK;
			first_pll_divider_sync <= 1'b0;
			second_pll_divider_sync <= 1'b0;
			out4_source_pick <= OCSS_RST_PICK4;
			out5_source_pick <= OCSS_RST_PICK5;
			out6_source_pick <= OCSS_RST_PICK6;
			out7_source_pick <= OCSS_RST_PICK7;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				OCSS_ADDR_SYNC_LOW: begin
					out_pick <= i_reg_wdata[3:0];
					first_pll_divider_sync <= i_reg_wdata[OCSS_POS_SYNC0];
					second_pll_divider_sync <= i_reg_wdata[OCSS_POS_SYNC1];
				end
				OCSS_ADDR_OUT45: begin
					out4_source_pick <= i_reg_wdata[OCSS_POS_HI_PICK +: 3];
					out5_source_pick <= i_reg_wdata[OCSS_POS_LO_PICK +: 3];
				end
				OCSS_ADDR_OUT67: begin
					out6_source_pick <= i_reg_wdata[OCSS_POS_HI_PICK +: 3];
					out7_source_pick <= i_reg_wdata[OCSS_POS_LO_PICK +: 3];
				end
				default: begin
					// Reserved and unmapped addresses ignore writes
				end
			endcase
		end
	end

	// Read mux, registered; reserved positions return zero
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_reg_rdata <= OCSS_RSVD_READ;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				OCSS_ADDR_SYNC_LOW: o_reg_rdata <= {2'b00, second_pll_divider_sync,
					first_pll_divider_sync, out_pick};
				OCSS_ADDR_OUT45: o_reg_rdata <= {1'b0, out5_source_pick, 1'b0, out4_source_pick};
				OCSS_ADDR_OUT67: o_reg_rdata <= {1'b0, out7_source_pick, 1'b0, out6_source_pick};
				default: o_reg_rdata <= OCSS_RSVD_READ;
			endcase
		end
	end

	// ************************************************
	// Sync sequencers, one per PLL
	// ************************************************
	ocss_sync_ctl u_sync_first (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_sync_bit(first_pll_divider_sync),
		.o_hold(hold0),
		.o_release(rel0)
	);

	ocss_sync_ctl u_sync_second (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_sync_bit(second_pll_divider_sync),
		.o_hold(hold1),
		.o_release(rel1)
	);

	// ************************************************
	// Source decode
	// ************************************************
	// Outputs 4-7 that pick output 2 or 3 inherit that output's PLL, since
	// their clock passes through that divider's PLL root
	function automatic logic [1:0] ocss_pll_of(input logic [2:0] code,
		input logic pll_of_2, input logic pll_of_3);
		logic [1:0] r;
		r = 2'b00;
		case (code)
			OCSS_SRC_FIRST_PLL: r = 2'b01;
			OCSS_SRC_SECOND_PLL: r = 2'b10;
			OCSS_SRC_OUT2: r = pll_of_2 ? 2'b10 : 2'b01;
			OCSS_SRC_OUT3: r = pll_of_3 ? 2'b10 : 2'b01;
			default: r = 2'b00; // Input references and crystal: no PLL
		endcase
		return r;
	endfunction

	// Which PLL drives each output, from the live selects
	always_comb begin
		logic [1:0] p;
		p = 2'b00;
		next_first = '0;
		next_second = '0;
		for (int m = 0; m < 4; m++) begin
			next_first[m] = !out_pick[m];
			next_second[m] = out_pick[m];
		end
		p = ocss_pll_of(out4_source_pick, out_pick[2], out_pick[3]);
		next_first[4] = p[0];
		next_second[4] = p[1];
		p = ocss_pll_of(out5_source_pick, out_pick[2], out_pick[3]);
		next_first[5] = p[0];
		next_second[5] = p[1];
		p = ocss_pll_of(out6_source_pick, out_pick[2], out_pick[3]);
		next_first[6] = p[0];
		next_second[6] = p[1];
		p = ocss_pll_of(out7_source_pick, out_pick[2], out_pick[3]);
		next_first[7] = p[0];
		next_second[7] = p[1];
	end

	// Mirror selects and PLL membership to the divider fabric
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_low_pick <= OCSS_RST_LOW_PICK;
			o_out4_source_pick <= OCSS_RST_PICK4;
			o_out5_source_pick <= OCSS_RST_PICK5;
			o_out6_source_pick <= OCSS_RST_PICK6;
			o_out7_source_pick <= OCSS_RST_PICK7;
			o_reg_out_pick_code <= {4'h0, OCSS_RST_LOW_PICK};
			o_from_first_pll <= '0;
			o_from_second_pll <= '0;
		end else begin
			o_low_pick <= out_pick;
			o_out4_source_pick <= out4_source_pick;
			o_out5_source_pick <= out5_source_pick;
			o_out6_source_pick <= out6_source_pick;
			o_out7_source_pick <= out7_source_pick;
			o_reg_out_pick_code <= {2'b00, second_pll_divider_sync,
				first_pll_divider_sync, out_pick};
			o_from_first_pll <= next_first;
			o_from_second_pll <= next_second;
		end
	end

	// ************************************************
	// Divider hold, release and phase effects
	// ************************************************
	// Hold and release are gated by the live selects, so a divider moved
	// to another PLL while held is released by the next settled cycle
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_div_hold <= '0;
			o_coarse_clear <= '0;
			o_fine_apply <= '0;
		end else begin
			for (int m = 0; m < NUM_OUT; m++) begin
				o_div_hold[m] <= (hold0 && next_first[m]) || (hold1 && next_second[m]);
				o_coarse_clear[m] <= (rel0 && next_first[m]) || (rel1 && next_second[m]);
				// Fine phase exists only on outputs 2 and 3
				o_fine_apply[m] <= (m == 2 || m == 3) &&
					((rel0 && next_first[m]) || (rel1 && next_second[m]));
			end
		end
	end

endmodule

// ### verification/ocss_checker.sv
// Concurrent checks on the source select block ports
`timescale 1ns/1ps
module ocss_checker
	import ocss_pkg::*;
#(
	parameter int NUM_OUT = OCSS_NUM_OUT // Output count
)(
	input wire logic i_clk, // Clock
	input wire logic i_arst_n, // Reset, active low
	input wire logic [15:0] i_reg_addr, // Address
	input wire logic [7:0] i_reg_wdata, // Write data
	input wire logic i_reg_wr, // Write strobe
	input wire logic i_reg_rd, // Read strobe
	input wire logic [7:0] o_reg_rdata, // Read data
	input wire logic [7:0] o_reg_out_pick_code, // Copy of 0xA8
	input wire logic [3:0] o_low_pick, // Low selects
	input wire logic [2:0] o_out4_source_pick, // Output 4 code
	input wire logic [NUM_OUT-1:0] o_from_first_pll, // First PLL map
	input wire logic [NUM_OUT-1:0] o_from_second_pll, // Second PLL map
	input wire logic [NUM_OUT-1:0] o_div_hold, // Held dividers
	input wire logic [NUM_OUT-1:0] o_coarse_clear // Clear pulses
);
	// ******
	// Checks
	// ******
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// Write to the sync and low select register
	wire wr_low = i_reg_wr && i_reg_addr == OCSS_ADDR_SYNC_LOW;
	// Selector ports sit two edges behind the write: register, then port copy
	a_low_pick_write: assert property (wr_low
		|-> ##2 o_low_pick == $past(i_reg_wdata[3:0], 2)) else $error("low select not written");
	a_pick4_write: assert property (i_reg_wr && i_reg_addr == OCSS_ADDR_OUT45
		|-> ##2 o_out4_source_pick == $past(i_reg_wdata[2:0], 2))
		else $error("pick4 not written");
	a_rsvd_read: assert property (i_reg_rd && i_reg_addr == OCSS_ADDR_RSVD
		|=> o_reg_rdata == 8'h00) else $error("reserved read not zero");
	a_hold_on_rise: assert property (wr_low && i_reg_wdata[4] && !i_reg_wdata[0]
		&& !o_reg_out_pick_code[4] |-> ##[2:3] o_div_hold[0]) else $error("no hold");
	a_clear_on_fall: assert property (wr_low && !i_reg_wdata[4] && !i_reg_wdata[0]
		&& o_reg_out_pick_code[4] && !o_low_pick[0] |-> ##[2:3] o_coarse_clear[0])
		else $error("no clear");
	a_clear_pulse: assert property (o_coarse_clear[0] |=> !o_coarse_clear[0])
		else $error("clear too long");
	a_clear_drops_hold: assert property (o_coarse_clear[0] |-> !o_div_hold[0]
		&& $past(o_div_hold[0])) else $error("clear without release");
	a_clear_affected: assert property ((o_coarse_clear & ~(o_from_first_pll
		| o_from_second_pll)) == '0) else $error("clear on unaffected output");
	// Map and select ports load on the same edge; only judged once both settled
	a_low_route: assert property ($past(i_arst_n, 2) && $stable(o_low_pick)
		|-> {o_from_first_pll[3:0], o_from_second_pll[3:0]} == {~o_low_pick, o_low_pick})
		else $error("low route wrong");
	cover property (o_div_hold[0]);
	cover property (o_coarse_clear != '0);
	cover property (i_reg_rd && i_reg_addr == OCSS_ADDR_RSVD);
endmodule
bind ocss_top ocss_checker #(.NUM_OUT(NUM_OUT)) u_ocss_checker (.i_clk, .i_arst_n,
	.i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_out_pick_code,
	.o_low_pick, .o_out4_source_pick, .o_from_first_pll, .o_from_second_pll,
	.o_div_hold, .o_coarse_clear);

// ### verification/tb_top.sv
// Self-checking bench for the source select block
`timescale 1ns/1ps
module tb_top;
	import ocss_pkg::*;
	logic i_clk, i_arst_n, i_reg_wr, i_reg_rd;
	logic [15:0] i_reg_addr;
	logic [7:0] i_reg_wdata, rdata, code, ff, fs, hold, clr, fine;
	logic [3:0] lp;
	logic [2:0] p4, p5, p6, p7;
	logic [31:0] lfsr = 32'h1fde_c027;
	int rg[4], msk[4] = '{15, 119, 119, 0};
	int miscompares = 0, check_count = 0, k, p, n, hp;
	ocss_top #(.NUM_OUT(8)) u_ocss_top (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .o_reg_rdata(rdata), .o_reg_out_pick_code(code),
		.o_low_pick(lp), .o_out4_source_pick(p4), .o_out5_source_pick(p5),
		.o_out6_source_pick(p6), .o_out7_source_pick(p7), .o_from_first_pll(ff),
		.o_from_second_pll(fs), .o_div_hold(hold), .o_coarse_clear(clr), .o_fine_apply(fine));
	// ******
	// Model
	// ******
	function automatic logic [31:0] lf(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Outputs fed by PLL p; 4-7 follow output 2 or 3 when chained
	function automatic int fm(input int p);
		int m, s, r;
		r = 0;
		for (m = 0; m < 8; m++) begin
			s = (m < 4) ? ((rg[0] >> m) & 1) : ((rg[m / 2 - 1] >> (4 * (m % 2))) & 7);
			if (m > 3 && (s == 2 || s == 3))
				s = (rg[0] >> s) & 1;
			if (s == p)
				r |= 1 << m;
		end
		return r;
	endfunction
	task chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One register write, model follows mapped addresses only
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1;
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(posedge i_clk);
		#1;
		i_reg_wr = 1'b0;
		if (a >= OCSS_ADDR_SYNC_LOW && a <= OCSS_ADDR_OUT67)
			rg[a - OCSS_ADDR_SYNC_LOW] = d;
	endtask
	task rd(input logic [15:0] a, input int e);
		@(posedge i_clk);
		#1;
		i_reg_addr = a;
		i_reg_rd = 1'b1;
		@(posedge i_clk);
		#1;
		i_reg_rd = 1'b0;
		chk(rdata, e[7:0]);
	endtask
	// Selector ports lag one cycle behind the register
	task ports;
		@(posedge i_clk);
		#1;
		chk(code, rg[0][7:0]);
		chk({4'h0, lp}, rg[0][7:0] & 8'h0f);
		chk({1'b0, p5, 1'b0, p4}, rg[1][7:0]);
		chk({1'b0, p7, 1'b0, p6}, rg[2][7:0]);
		chk(ff, 8'(fm(0)));
		chk(fs, 8'(fm(1)));
		chk(hold, 8'h00);
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ******
	// Stimulus
	// ******
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#(25 * 20000);
		miscompares++;
		conclude;
	end
	initial begin
		{i_arst_n, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
		rg = '{10, 32, 86, 0};
		repeat (20) @(posedge i_clk);
		#1;
		i_arst_n = 1'b1;
		ports;
		for (k = 0; k < 4; k++)
			rd(OCSS_ADDR_SYNC_LOW + 16'(k), rg[k]);
		rd(16'h00a7, 0);
		$display("test reset_defaults done");
		// Random selects, reserved bits kept zero by the writer; the bench
		// drives no reference clocks, so every reference counts as slow enough
		repeat (40) begin
			lfsr = lf(lfsr);
			k = int'(lfsr[1:0]);
			wr(OCSS_ADDR_SYNC_LOW + 16'(k), lfsr[15:8] & 8'(msk[k]));
			rd(OCSS_ADDR_SYNC_LOW + 16'(k), rg[k]);
			ports;
		end
		$display("test random_selects done");
		for (k = 0; k < 8; k++) begin
			wr(OCSS_ADDR_OUT45, {1'b0, 3'(7 - k), 1'b0, 3'(k)});
			ports;
		end
		$display("test wide_decode done");
		wr(OCSS_ADDR_SYNC_LOW, 8'h06);
		for (p = 0; p < 2; p++) begin
			wr(OCSS_ADDR_SYNC_LOW, 8'(rg[0] | (16 << p)));
			repeat (3) @(posedge i_clk);
			#1;
			hp = fm(p);
			chk(hold, 8'(hp));
			wr(OCSS_ADDR_SYNC_LOW, 8'(rg[0] & 15));
			for (n = 0; clr === 8'h00 && n < 5; n++) begin
				@(posedge i_clk);
				#1;
			end
			chk(clr, 8'(hp));
			chk(fine, 8'(hp & 12));
			chk(hold, 8'h00);
		end
		$display("test divider_sync done");
		conclude;
	end
endmodule
